// [logic/lsu_barrier_pkg.sv]
// shared types and constants for the store path and memory barrier block
package lsu_barrier_pkg;

  // datapath geometry
  localparam int unsigned WORD_BYTES = 4;    // bytes in a word
  localparam int unsigned BYTE_BITS  = 8;    // bits in a byte

  // barrier type field position in the instruction word
  localparam int unsigned STYPE_LSB = 6;
  localparam int unsigned STYPE_MSB = 10;

  // barrier type codes with distinct behaviour
  localparam logic [4:0] STYPE_FULL      = 5'h00;  // completion, all classes
  localparam logic [4:0] STYPE_STORES    = 5'h04;  // ordering, stores
  localparam logic [4:0] STYPE_ALL_ORDER = 5'h10;  // ordering, loads and stores
  localparam logic [4:0] STYPE_ACQUIRE   = 5'h11;  // older loads before all younger
  localparam logic [4:0] STYPE_RELEASE   = 5'h12;  // all older before younger stores
  localparam logic [4:0] STYPE_LOADS     = 5'h13;  // ordering, loads

  // register byte offsets on the bus
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_BAR_COUNT = 8'h08;

  // control register field positions and reset value
  localparam int unsigned CTRL_PROC_BE  = 0;  // processor big endian flag
  localparam int unsigned CTRL_MEM_BE   = 1;  // memory big endian flag
  localparam int unsigned CTRL_REV_END  = 2;  // reverse endian flag
  localparam int unsigned CTRL_LIGHT_EN = 3;  // enable lighter barrier types
  localparam int unsigned CTRL_W        = 4;
  localparam logic [3:0]  CTRL_RESET    = 4'h8;

  // outstanding counter indices
  localparam int unsigned CNT_LD     = 0;  // synchronizable loads
  localparam int unsigned CNT_ST     = 1;  // synchronizable stores
  localparam int unsigned CNT_LD_EXT = 2;  // uncached loads on the external bus
  localparam int unsigned CNT_ST_EXT = 3;  // uncached stores on the external bus
  localparam int unsigned CNT_NUM    = 4;

  // memory operation kinds coming from the pipeline
  typedef enum logic [2:0] {
    OP_LOAD, OP_STORE, OP_STORE_RIGHT, OP_STORE_IDX_FP, OP_CACHE, OP_PREFETCH, OP_BARRIER
  } op_kind_t;

  // cacheability attribute of the access
  typedef enum logic [1:0] {CCA_UNCACHED, CCA_COHERENT, CCA_NONCOHERENT, CCA_OTHER} cca_t;

  // translation outcome reported with the request
  typedef enum logic [2:0] {XLAT_OK, XLAT_REFILL, XLAT_INVALID, XLAT_MODIFIED, XLAT_ADDR_ERR} xlat_t;

  // exception reported back to the pipeline
  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESERVED, EXC_COP_UNUSABLE, EXC_ADDR_ERR,
    EXC_XLAT_REFILL, EXC_XLAT_INVALID, EXC_XLAT_MODIFIED, EXC_WATCH
  } exc_t;

  // one memory operation as issued by the pipeline
  typedef struct packed {
    op_kind_t    kind;
    logic [31:0] instr;        // instruction word, barrier type lives here
    logic [31:0] base;         // base general register
    logic [31:0] index;        // index general register
    logic [15:0] offset;       // signed displacement
    logic [31:0] rt_data;      // source general register
    logic [63:0] fp_data;      // source float register
    logic        shared;       // target is shared memory
    cca_t        cca;
    xlat_t       xlat;
    logic        watch;        // watch match on this address
    logic        cop1_usable;
    logic        r2_enabled;   // indexed float ops implemented
  } op_req_t;

  // request handed to the cache
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [2:0]  size;         // byte count, 1 to 4
    logic        is_store;
    logic        sync;
    logic        ext;
  } mem_req_t;

  // completion report from the cache
  typedef struct packed {
    logic valid;
    logic is_store;
    logic sync;
    logic ext;
    logic bus_err;
  } mem_done_t;

  // decoded scope of a barrier
  typedef struct packed {
    logic old_ld;
    logic old_st;
    logic yng_ld;
    logic yng_st;
    logic complete;            // completion rather than ordering
  } bar_scope_t;

endpackage : lsu_barrier_pkg

// [logic/store_former.sv]
// address and data forming for loads, stores and the partial store
`timescale 1ns/1ps
module store_former
  import lsu_barrier_pkg::*;
(
  input  wire op_req_t     req_i,
  input  wire logic        proc_be_i,
  input  wire logic        mem_be_i,
  input  wire logic        rev_endian_i,
  output logic      [31:0] addr_o,
  output logic      [31:0] data_o,
  output logic      [2:0]  size_o,
  output logic             align_fault_o
);

  wire        is_rp    = (req_i.kind == OP_STORE_RIGHT);   // partial right store
  wire        is_idx   = (req_i.kind == OP_STORE_IDX_FP);  // indexed float store
  wire        is_word  = (req_i.kind == OP_LOAD) || (req_i.kind == OP_STORE) || is_idx;
  wire [31:0] sext_off = {{16{req_i.offset[15]}}, req_i.offset};
  wire [31:0] ea_disp  = req_i.base + sext_off;
  // indexed form adds two registers and no displacement
  wire [31:0] ea_idx   = req_i.base + req_i.index;
  wire [31:0] ea       = is_idx ? ea_idx : ea_disp;

  // byte index from address and processor byte order
  wire [1:0]  byte_idx = ea[1:0] ^ {2{proc_be_i}};
  wire [4:0]  shamt    = {byte_idx, 3'b000};
  wire [31:0] rp_data  = req_i.rt_data << shamt;
  wire [2:0]  rp_size  = 3'(WORD_BYTES) - {1'b0, byte_idx};

  // physical low bits: reverse endian swap, cleared for little endian memory
  wire [1:0]  rp_lo    = mem_be_i ? (ea[1:0] ^ {2{rev_endian_i}}) : 2'b00;

  // translation sits outside; addresses leave this block untranslated
  assign addr_o = is_rp ? {ea[31:2], rp_lo} : ea;
  // indexed float store takes the low word, uninterpreted
  assign data_o = is_rp ? rp_data : (is_idx ? req_i.fp_data[31:0] : req_i.rt_data);
  assign size_o = is_rp ? rp_size : 3'(WORD_BYTES);
  // only whole-word ops are checked; the partial store has no alignment limit
  assign align_fault_o = is_word && (ea[1:0] != 2'b00);

endmodule : store_former

// [logic/lsu_barrier_ctrl.sv]
// load/store issue stage with partial store, indexed float store and barrier
// Summary of operation
// - partial store bytes follow address and byte order
// - byte index shifts data, store width shrinks
// - partial store unaligned; limited exception set only
// - indexed float store adds base and index
// - misaligned indexed float store raises address error
// - indexed float store writes low word whole
// - indexed float store reserved or unusable faults
// - barrier type from bits ten to six
// - completion barrier waits older synchronizable ops performed
// - load done at writeback, store when visible
// - type zero: full completion barrier, all classes
// - undefined nonzero types behave like type zero
// - ordering barrier: older pass ordering point first
// - older external request performed before younger one
// - cache and prefetch count as loads and stores; as older ops, cache counts as a store only, prefetch as a load only
// - software brackets mode changes with completion barrier
// - type codes select ordered load/store scope
// - synchronizable means shared, uncached or coherent
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module lsu_barrier_ctrl
  import lsu_barrier_pkg::*;
#(
  parameter int unsigned CNT_W = 4   // width of each outstanding counter
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // register bus, classic single cycle slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // operations from the pipeline
  input  wire logic             in_valid_i,
  input  wire op_req_t          in_req_i,
  output logic                  in_ready_o,
  // request port toward the cache
  output logic                  mem_valid_o,
  output mem_req_t              mem_req_o,
  input  wire logic             mem_ready_i,
  input  wire mem_done_t        mem_done_i,
  // exception and status reporting
  output logic                  exc_valid_o,
  output exc_t                  exc_code_o,
  output logic                  bus_error_o,
  output logic                  bar_busy_o
);


  // state

  logic [CTRL_W-1:0] ctrl;            // software control bits
  logic [15:0]       bar_count;       // barriers retired since reset
  logic              hold_v;          // one-entry hold register is full
  op_req_t           hold;            // operation waiting to issue
  logic              bar_v;           // a barrier is pending
  bar_scope_t        bar;             // scope of the pending barrier
  logic [CNT_W-1:0]  cnt [CNT_NUM];   // outstanding synchronizable ops


  // address and data forming

  logic [31:0] f_addr;      // formed address
  logic [31:0] f_data;      // formed store data
  logic [2:0]  f_size;      // byte count
  logic        f_align;     // alignment fault

  store_former u_former (
    .req_i         (hold),
    .proc_be_i     (ctrl[CTRL_PROC_BE]),
    .mem_be_i      (ctrl[CTRL_MEM_BE]),
    .rev_endian_i  (ctrl[CTRL_REV_END]),
    .addr_o        (f_addr),
    .data_o        (f_data),
    .size_o        (f_size),
    .align_fault_o (f_align)
  );


  // classification of the held operation

  wire is_bar   = (hold.kind == OP_BARRIER);
  wire is_maint = (hold.kind == OP_CACHE) || (hold.kind == OP_PREFETCH);
  wire is_store = (hold.kind == OP_STORE) || (hold.kind == OP_STORE_RIGHT)
               || (hold.kind == OP_STORE_IDX_FP) || (hold.kind == OP_CACHE);
  wire is_idx   = (hold.kind == OP_STORE_IDX_FP);
  // cache maintenance and prefetch are caught by load and store scopes alike
  wire cls_ld   = !is_store || is_maint;
  wire cls_st   = is_store || is_maint;
  // only shared uncached or coherent accesses are synchronizable
  wire op_sync  = hold.shared
               && (hold.cca == CCA_UNCACHED || hold.cca == CCA_COHERENT);
  wire op_ext   = op_sync && (hold.cca == CCA_UNCACHED);


  // exception selection, priority from decode faults down to watch

  wire  exc_ri  = is_idx && !hold.r2_enabled;
  wire  exc_cpu = is_idx && !hold.cop1_usable;
  // the partial store never reaches the alignment term (former masks it)
  wire exc_t op_exc =
      exc_ri                        ? EXC_RESERVED      :
      exc_cpu                       ? EXC_COP_UNUSABLE  :
      f_align                       ? EXC_ADDR_ERR      :
      (hold.xlat == XLAT_ADDR_ERR)  ? EXC_ADDR_ERR      :
      (hold.xlat == XLAT_REFILL)    ? EXC_XLAT_REFILL   :
      (hold.xlat == XLAT_INVALID)   ? EXC_XLAT_INVALID  :
      (hold.xlat == XLAT_MODIFIED)  ? EXC_XLAT_MODIFIED :
      hold.watch                    ? EXC_WATCH         :
                                      EXC_NONE;
  wire op_fault = (op_exc != EXC_NONE);


  // barrier type decode

  wire [4:0] stype = hold.instr[STYPE_MSB:STYPE_LSB];

  function automatic bar_scope_t decode_scope(input logic [4:0] t, input logic light);
    bar_scope_t s;
    s = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b1, yng_st: 1'b1, complete: 1'b1};
    // unlisted codes, and all codes when lighter types are off, stay full
    if (light) begin
      unique case (t)
        STYPE_STORES:    s = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        STYPE_ALL_ORDER: s = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        STYPE_ACQUIRE:   s = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        STYPE_RELEASE:   s = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        STYPE_LOADS:     s = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        default:         s = s;
      endcase
    end
    return s;
  endfunction : decode_scope

  wire bar_scope_t new_scope = decode_scope(stype, ctrl[CTRL_LIGHT_EN]);


  // outstanding counters

  wire issue_fire = mem_valid_o && mem_ready_i;   // cache took the slot
  wire done_v     = mem_done_i.valid;
  logic [CNT_NUM-1:0] cnt_inc;                    // per counter increment
  logic [CNT_NUM-1:0] cnt_dec;                    // per counter decrement
  logic [CNT_NUM-1:0] cnt_zero;                   // per counter drained
  logic [CNT_NUM-1:0] cnt_full;                   // per counter saturated

  // loads retire at register writeback, stores at global visibility
  assign cnt_inc[CNT_LD]     = issue_fire && mem_req_o.sync && !mem_req_o.is_store;
  assign cnt_inc[CNT_ST]     = issue_fire && mem_req_o.sync && mem_req_o.is_store;
  assign cnt_inc[CNT_LD_EXT] = issue_fire && mem_req_o.ext && !mem_req_o.is_store;
  assign cnt_inc[CNT_ST_EXT] = issue_fire && mem_req_o.ext && mem_req_o.is_store;
  assign cnt_dec[CNT_LD]     = done_v && mem_done_i.sync && !mem_done_i.is_store;
  assign cnt_dec[CNT_ST]     = done_v && mem_done_i.sync && mem_done_i.is_store;
  assign cnt_dec[CNT_LD_EXT] = done_v && mem_done_i.ext && !mem_done_i.is_store;
  assign cnt_dec[CNT_ST_EXT] = done_v && mem_done_i.ext && mem_done_i.is_store;

  // one counter per tracked class
  for (genvar g = 0; g < CNT_NUM; g++) begin : g_cnt
    assign cnt_zero[g] = (cnt[g] == '0);
    assign cnt_full[g] = &cnt[g];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt[g] <= '0;
      end else if (cnt_inc[g] && !cnt_dec[g]) begin
        cnt[g] <= cnt[g] + 1'b1;
      end else if (cnt_dec[g] && !cnt_inc[g] && !cnt_zero[g]) begin
        cnt[g] <= cnt[g] - 1'b1;
      end
    end
  end


  // barrier release

  // completion waits for older ops globally performed
  wire done_cmp = (!bar.old_ld || cnt_zero[CNT_LD])
               && (!bar.old_st || cnt_zero[CNT_ST]);
  // ordering needs only the ordering point (cache slot accepted) plus
  // older external requests performed before younger ones go out
  wire done_ord = (!bar.old_ld || cnt_zero[CNT_LD_EXT])
               && (!bar.old_st || cnt_zero[CNT_ST_EXT]);
  wire bar_done = bar_v && !mem_valid_o
               && (bar.complete ? done_cmp : done_ord);


  // issue decisions for the held operation

  wire slot_free  = !mem_valid_o || mem_ready_i;
  wire any_full   = |cnt_full;      // stop issuing while any counter reads all ones
  // younger synchronizable ops of the selected classes wait behind a pending barrier; others pass
  wire op_blocked = bar_v && op_sync
                 && ((bar.yng_ld && cls_ld) || (bar.yng_st && cls_st));
  wire bar_accept = hold_v && is_bar && !bar_v;
  wire op_go      = hold_v && !is_bar && !op_blocked
                 && (op_fault || (slot_free && !any_full));
  wire op_issue   = op_go && !op_fault;
  wire in_take    = in_valid_i && in_ready_o;
  wire hold_clear = bar_accept || op_go;
  wire next_hold_v = in_take || (hold_v && !hold_clear);

  // hold register and the ready it drives; a new op enters only when empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_v     <= 1'b0;
      hold       <= '0;
      in_ready_o <= 1'b0;
    end else begin
      hold_v     <= next_hold_v;
      in_ready_o <= !next_hold_v;
      if (in_take) begin
        hold <= in_req_i;
      end
    end
  end

  // pending barrier; a second barrier waits in the hold register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bar_v     <= 1'b0;
      bar       <= '0;
      bar_count <= '0;
    end else if (bar_accept) begin
      bar_v <= 1'b1;
      bar   <= new_scope;
    end else if (bar_done) begin
      bar_v     <= 1'b0;
      bar_count <= bar_count + 1'b1;
    end
  end

  // cache request slot, held until the cache accepts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_valid_o <= 1'b0;
      mem_req_o   <= '0;
    end else if (op_issue) begin
      mem_valid_o        <= 1'b1;
      mem_req_o.addr     <= f_addr;
      mem_req_o.data     <= f_data;
      mem_req_o.size     <= f_size;
      mem_req_o.is_store <= is_store;
      mem_req_o.sync     <= op_sync;
      mem_req_o.ext      <= op_ext;
    end else if (mem_ready_i) begin
      mem_valid_o <= 1'b0;
    end
  end

  // exception pulse for a faulting op, which is dropped without access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_valid_o <= 1'b0;
      exc_code_o  <= EXC_NONE;
      bus_error_o <= 1'b0;
      bar_busy_o  <= 1'b0;
    end else begin
      exc_valid_o <= op_go && op_fault;
      exc_code_o  <= (op_go && op_fault) ? op_exc : EXC_NONE;
      // bus errors arrive late, with the completion report
      bus_error_o <= done_v && mem_done_i.bus_err;
      bar_busy_o  <= bar_v ? !bar_done : bar_accept;
    end
  end


  // register bus slave

  wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        sel_ctrl = (wb_adr_i == REG_CTRL);
  wire        sel_stat = (wb_adr_i == REG_STATUS);
  wire        sel_bcnt = (wb_adr_i == REG_BAR_COUNT);
  wire [31:0] stat_word = {8'h00,
                           4'(cnt[CNT_ST_EXT]), 4'(cnt[CNT_LD_EXT]),
                           4'(cnt[CNT_ST]), 4'(cnt[CNT_LD]),
                           3'h0, mem_valid_o, hold_v, bar.complete, bar_v, 1'b0};
  // unmapped addresses read zero and ignore writes
  wire [31:0] rd_word  = sel_ctrl ? {28'h0000000, ctrl} :
                         sel_stat ? stat_word :
                         sel_bcnt ? {16'h0000, bar_count} : 32'h00000000;

  // one-cycle ack; the ack term stops a held strobe from repeating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl     <= CTRL_RESET;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h00000000;
      if (wb_req && wb_we_i && sel_ctrl && wb_sel_i[0]) begin
        ctrl <= wb_dat_i[CTRL_W-1:0];
      end
    end
  end

endmodule : lsu_barrier_ctrl

// [dv/lsu_barrier_ctrl_monitor.sv]
// port-level checks for the store path and memory barrier block
`timescale 1ns/1ps
module lsu_barrier_ctrl_monitor
  import lsu_barrier_pkg::*;
#(
  parameter int unsigned CNT_W = 4  // counter width, handed on by the bind
) (
  input wire logic      clk_i,
  input wire logic      rst_i,
  input wire logic      wb_cyc_i,
  input wire logic      wb_stb_i,
  input wire logic      wb_ack_o,
  input wire logic      in_valid_i,
  input wire op_req_t   in_req_i,
  input wire logic      in_ready_o,
  input wire logic      mem_valid_o,
  input wire mem_req_t  mem_req_o,
  input wire logic      mem_ready_i,
  input wire mem_done_t mem_done_i,
  input wire logic      exc_valid_o,
  input wire exc_t      exc_code_o,
  input wire logic      bus_error_o,
  input wire logic      bar_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  sync_out;  // synchronizable ops accepted by the cache, not yet done
  logic        full_bar;  // last barrier taken had a code outside the lighter set
  wire         take    = in_valid_i && in_ready_o;
  wire  [4:0]  stype   = in_req_i.instr[STYPE_MSB:STYPE_LSB];
  wire         fp_take = take && (in_req_i.kind == OP_STORE_IDX_FP);
  wire  [31:0] fp_ea   = in_req_i.base + in_req_i.index;
  // mirror of outstanding work; only lighter codes are treated as ordering, so
  // a disabled light mode merely skips the drain check
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_out <= 8'h00;
      full_bar <= 1'b0;
    end else begin
      sync_out <= sync_out + 8'(mem_valid_o && mem_ready_i && mem_req_o.sync)
                  - 8'(mem_done_i.valid && mem_done_i.sync);
      if (take && (in_req_i.kind == OP_BARRIER)) begin
        full_bar <= !(stype inside {STYPE_STORES, STYPE_ALL_ORDER, STYPE_ACQUIRE, STYPE_RELEASE, STYPE_LOADS});
      end
    end
  end
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus cycle not answered after one cycle");
  AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_HOLD: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_req_o))
    else $error("cache request changed before acceptance");
  AST_SIZE: assert property (mem_valid_o |-> mem_req_o.size inside {[3'h1:3'h4]})
    else $error("store size outside one to four bytes");
  AST_FP_ALIGN: assert property (fp_take && in_req_i.r2_enabled && in_req_i.cop1_usable && fp_ea[1:0] != 2'h0
    |-> ##[1:3] exc_valid_o && exc_code_o == EXC_ADDR_ERR) else $error("misaligned indexed store not faulted");
  AST_FP_RSVD: assert property (fp_take && !in_req_i.r2_enabled
    |-> ##[1:3] exc_valid_o && exc_code_o == EXC_RESERVED) else $error("reserved fault missing");
  AST_BUS_ERR: assert property (mem_done_i.valid && mem_done_i.bus_err |=> bus_error_o)
    else $error("bus error not reported");
  AST_FULL_DRAIN: assert property (full_bar && $fell(bar_busy_o) |-> sync_out == 8'h00)
    else $error("completion barrier retired with work outstanding");
  AST_EXC_IDLE: assert property (!exc_valid_o |-> exc_code_o == EXC_NONE)
    else $error("fault code shown without fault pulse");
endmodule : lsu_barrier_ctrl_monitor

bind lsu_barrier_ctrl lsu_barrier_ctrl_monitor #(.CNT_W(CNT_W)) mon (.*);

// [dv/cache_model.sv]
// cache side model: accepts requests and reports completion after a set delay
`timescale 1ns/1ps
module cache_model
  import lsu_barrier_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,      // hold off acceptance
  input  wire logic [7:0] lat_i,        // cycles from acceptance to done
  input  wire logic       err_i,        // mark dones of accepted ops as bus errors
  input  wire logic       mem_valid_i,
  input  wire mem_req_t   mem_req_i,
  output logic            mem_ready_o,
  output mem_done_t       mem_done_o
);
  int unsigned now = 0;     // local cycle count
  int unsigned due[$];      // done deadline per accepted op
  mem_done_t   info[$];     // report per accepted op
  // reports leave in acceptance order, so visibility follows program order
  always @(posedge clk_i) begin
    now <= now + 1;
    mem_ready_o <= !rst_i && !stall_i;
    mem_done_o <= '0;
    if (rst_i) begin
      due.delete();
      info.delete();
    end else begin
      if (mem_valid_i && mem_ready_o) begin
        due.push_back(now + lat_i);
        info.push_back({1'b1, mem_req_i.is_store, mem_req_i.sync, mem_req_i.ext, err_i});
      end
      if (due.size() > 0 && due[0] <= now) begin
        mem_done_o <= info.pop_front();
        void'(due.pop_front());
      end
    end
  end
endmodule : cache_model

// [dv/test_store_path_and_memory_barrier.sv]
// self-checking bench for the store path and memory barrier block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module test_store_path_and_memory_barrier import lsu_barrier_pkg::*;;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, in_valid = 0, stall = 0, err = 0, done_seen = 0;
  logic [7:0] adr = 8'h00, lat = 8'h02;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic wb_ack, in_ready, mem_valid, mem_ready, exc_valid, bus_err, bar_busy;
  op_req_t in_req = '0;
  mem_req_t mreq;
  mem_done_t mdone;
  exc_t ecode;
  int n_fail = 0, samples_checked = 0, cycles = 0;
  typedef struct {logic [3:0] c; op_kind_t k; logic [31:0] b, i; logic [15:0] o; logic [1:0] u; xlat_t x;
    logic [31:0] a, d; logic [2:0] s; exc_t e;} row_t;
  // ctrl, kind, base, index, offset, {r2, cop1}, translation, then expected addr, data, size, fault
  row_t rows[11] = '{
    '{4'h8, OP_STORE_RIGHT, 32'h100, 32'h0, 16'h1, 2'h3, XLAT_OK, 32'h100, 32'hb2c3d400, 3'h3, EXC_NONE},
    '{4'h9, OP_STORE_RIGHT, 32'h100, 32'h0, 16'h1, 2'h3, XLAT_OK, 32'h100, 32'hc3d40000, 3'h2, EXC_NONE},
    '{4'hb, OP_STORE_RIGHT, 32'h100, 32'h0, 16'h3, 2'h3, XLAT_OK, 32'h103, 32'ha1b2c3d4, 3'h4, EXC_NONE},
    '{4'hf, OP_STORE_RIGHT, 32'h100, 32'h0, 16'h2, 2'h3, XLAT_OK, 32'h101, 32'hb2c3d400, 3'h3, EXC_NONE},
    '{4'h8, OP_STORE_RIGHT, 32'h104, 32'h0, 16'hffff, 2'h3, XLAT_OK, 32'h100, 32'hd4000000, 3'h1, EXC_NONE},
    '{4'h8, OP_STORE_RIGHT, 32'h100, 32'h0, 16'h1, 2'h3, XLAT_REFILL, 32'h0, 32'h0, 3'h0, EXC_XLAT_REFILL},
    '{4'h8, OP_STORE_IDX_FP, 32'h200, 32'h10, 16'h0, 2'h3, XLAT_OK, 32'h210, 32'h55667788, 3'h4, EXC_NONE},
    '{4'h8, OP_STORE_IDX_FP, 32'h200, 32'h2, 16'h0, 2'h3, XLAT_OK, 32'h0, 32'h0, 3'h0, EXC_ADDR_ERR},
    '{4'h8, OP_STORE_IDX_FP, 32'h200, 32'h10, 16'h0, 2'h1, XLAT_OK, 32'h0, 32'h0, 3'h0, EXC_RESERVED},
    '{4'h8, OP_STORE_IDX_FP, 32'h200, 32'h10, 16'h0, 2'h2, XLAT_OK, 32'h0, 32'h0, 3'h0, EXC_COP_UNUSABLE},
    '{4'h8, OP_CACHE, 32'h400, 32'h0, 16'h4, 2'h3, XLAT_MODIFIED, 32'h0, 32'h0, 3'h0, EXC_XLAT_MODIFIED}};
  // {ctrl, barrier code, younger load must wait for the older store's done}
  logic [9:0] bars[9] = '{{4'h8, 5'h00, 1'b1}, {4'h8, 5'h01, 1'b1}, {4'h8, 5'h14, 1'b1}, {4'h8, 5'h10, 1'b0},
    {4'h8, 5'h04, 1'b0}, {4'h8, 5'h13, 1'b0}, {4'h8, 5'h11, 1'b0}, {4'h8, 5'h12, 1'b0}, {4'h0, 5'h10, 1'b1}};
  always #12.5 clk = ~clk;
  lsu_barrier_ctrl #(.CNT_W(4)) dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(wb_ack),
    .in_valid_i(in_valid), .in_req_i(in_req), .in_ready_o(in_ready), .mem_valid_o(mem_valid),
    .mem_req_o(mreq), .mem_ready_i(mem_ready), .mem_done_i(mdone), .exc_valid_o(exc_valid),
    .exc_code_o(ecode), .bus_error_o(bus_err), .bar_busy_o(bar_busy));
  cache_model cache (.clk_i(clk), .rst_i(rst), .stall_i(stall), .lat_i(lat), .err_i(err),
    .mem_valid_i(mem_valid), .mem_req_i(mreq), .mem_ready_o(mem_ready), .mem_done_o(mdone));
  // remember any completion since the flag was last cleared
  always @(posedge clk) if (mdone.valid === 1'b1) done_seen <= 1'b1;
  // hang guard, far above the run's length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin n_fail++; conclude(); end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // one classic single bus cycle, entered just after an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = rdat; cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic issue(input op_req_t r);
    in_req <= r; in_valid <= 1'b1;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    @(posedge clk); // gap before the next request
  endtask : issue
  function automatic op_req_t op(op_kind_t k, logic [31:0] b, i, logic [15:0] o, logic [1:0] u, xlat_t x,
      logic [4:0] st);
    op = '0; op.kind = k; op.base = b; op.index = i; op.offset = o; op.rt_data = 32'ha1b2c3d4;
    op.fp_data = 64'h1122334455667788; op.shared = 1'b1; op.cca = CCA_COHERENT; op.xlat = x;
    op.r2_enabled = u[1]; op.cop1_usable = u[0]; op.instr = {21'h0, st, 6'h00};
  endfunction : op
  initial begin
    int i;
    repeat (4) @(posedge clk);
    `CHK(in_ready, 1'b0)
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(q, 32'h8)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    $display("reset and register test done");
    err <= 1'b1;
    foreach (rows[n]) begin
      wb(1'b1, REG_CTRL, {28'h0, rows[n].c});
      stall <= 1'b1;
      issue(op(rows[n].k, rows[n].b, rows[n].i, rows[n].o, rows[n].u, rows[n].x, 5'h00));
      for (i = 0; i < 40 && mem_valid !== 1'b1 && exc_valid !== 1'b1; i++) @(posedge clk);
      `CHK(ecode, rows[n].e)
      if (rows[n].e == EXC_NONE) begin
        `CHK(mreq.addr, rows[n].a)
        `CHK(mreq.data, rows[n].d)
        `CHK(mreq.size, rows[n].s)
      end
      stall <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("store table test done");
    err <= 1'b0;
    lat <= 8'h1e;
    foreach (bars[n]) begin
      wb(1'b1, REG_CTRL, {28'h0, bars[n][9:6]});
      issue(op(OP_STORE, 32'h300, 32'h0, 16'h0, 2'h3, XLAT_OK, 5'h00));
      done_seen <= 1'b0;
      issue(op(OP_BARRIER, 32'h0, 32'h0, 16'h0, 2'h3, XLAT_OK, bars[n][5:1]));
      issue(op(OP_LOAD, 32'h304, 32'h0, 16'h0, 2'h3, XLAT_OK, 5'h00));
      for (i = 0; i < 100 && !(mem_valid === 1'b1 && mreq.is_store === 1'b0); i++) @(posedge clk);
      `CHK(done_seen, bars[n][0])
      repeat (50) @(posedge clk);
    end
    $display("barrier table test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(mem_valid, 1'b0)
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(q, 32'h8)
    $display("second reset test done");
    conclude();
  end
endmodule : test_store_path_and_memory_barrier
